/* File: bsl_dev.sv */
// sensor module end of the barometer serial command link
`timescale 1ns/100ps
`default_nettype none
`include "bsl_regs.svh"

module bsl_dev #(
  parameter int unsigned CONV_CYCLES = `BSL_CONV_CYCLES,
  parameter logic [63:0] CAL_STORE = `BSL_CAL_STORE
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  bsl_link_if.dev link,
  input wire logic [15:0] pres_value_in,
  input wire logic [15:0] temp_value_in,
  output logic busy_out,
  output logic [15:0] result_out
);
  import bsl_pkg::*;

  // word 0 is the most significant quarter of the store
  function automatic logic [15:0] cal_word(input logic [1:0] idx);
    logic [15:0] w;
    case (idx)
      2'h0: w = CAL_STORE[63:48];
      2'h1: w = CAL_STORE[47:32];
      2'h2: w = CAL_STORE[31:16];
      default: w = CAL_STORE[15:0];
    endcase
    return w;
  endfunction

  // link domain state, clocked by sclk
  bsl_dev_st_e state_r;
  bsl_dev_st_e state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [3:0] setup_r;
  logic [3:0] setup_nxt;
  logic [19:0] hist_r;
  logic dout_link_r;
  logic dout_link_nxt;
  logic req_tgl_r;
  logic req_tgl_nxt;
  logic temp_sel_r;
  logic temp_sel_nxt;
  logic rd_conv_r;
  logic rd_conv_nxt;
  logic [1:0] cal_idx_r;
  logic [1:0] cal_idx_nxt;

  // master domain state
  logic [2:0] tgl_sync_r;
  logic [2:0] dout_sync_r;
  logic busy_r;
  logic [23:0] conv_cnt_r;
  logic [15:0] result_r;
  logic dout_r;

  wire logic [20:0] hist_w;
  wire logic rst_hit_w;
  wire logic is_pres_w;
  wire logic is_temp_w;
  wire logic is_cal_w;
  wire logic [1:0] cal_code_idx_w;
  wire logic [15:0] rd_word_w;
  wire logic start_w;

  assign hist_w = {hist_r, link.din};
  assign rst_hit_w = (hist_w == `BSL_RST_PATTERN);
  assign is_pres_w = (setup_r == `BSL_SETUP_PRES);
  assign is_temp_w = (setup_r == `BSL_SETUP_TEMP);
  assign is_cal_w = (setup_r == `BSL_SETUP_CAL1) || (setup_r == `BSL_SETUP_CAL2) ||
                    (setup_r == `BSL_SETUP_CAL3) || (setup_r == `BSL_SETUP_CAL4);
  assign cal_code_idx_w = (setup_r == `BSL_SETUP_CAL1) ? 2'h0 :
                          (setup_r == `BSL_SETUP_CAL2) ? 2'h1 :
                          (setup_r == `BSL_SETUP_CAL3) ? 2'h2 : 2'h3;
  // result_r is quiet by the time the host clocks a readout, so the link side may read it directly
  assign rd_word_w = rd_conv_r ? result_r : cal_word(cal_idx_r);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    setup_nxt = setup_r;
    dout_link_nxt = dout_link_r;
    req_tgl_nxt = req_tgl_r;
    temp_sel_nxt = temp_sel_r;
    rd_conv_nxt = rd_conv_r;
    cal_idx_nxt = cal_idx_r;
    case (state_r)
      DS_IDLE: begin
        dout_link_nxt = 1'b0;
        if (link.din) begin
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_r == `BSL_START_BITS - 5'h01) begin
            state_nxt = DS_SETUP;
            cnt_nxt = 5'h00;
          end
        end else begin
          cnt_nxt = 5'h00;
        end
      end
      DS_SETUP: begin
        setup_nxt = {setup_r[2:0], link.din};
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == `BSL_SETUP_BITS - 5'h01) begin
          state_nxt = DS_STOP;
          cnt_nxt = 5'h00;
        end
      end
      DS_STOP: begin
        cnt_nxt = cnt_r + 5'h01;
        if (link.din) begin
          // a high stop bit means a broken frame: drop it and hunt for a new start
          state_nxt = DS_IDLE;
          cnt_nxt = 5'h00;
        end else if (cnt_r == `BSL_STOP_BITS - 5'h01) begin
          cnt_nxt = 5'h00;
          if (is_pres_w || is_temp_w) begin
            state_nxt = DS_ACK;
            dout_link_nxt = 1'b1;
            temp_sel_nxt = is_temp_w;
            rd_conv_nxt = 1'b1;
          end else if (is_cal_w) begin
            state_nxt = DS_READ;
            rd_conv_nxt = 1'b0;
            cal_idx_nxt = cal_code_idx_w;
          end else begin
            state_nxt = DS_IDLE;
          end
        end
      end
      DS_ACK: begin
        cnt_nxt = cnt_r + 5'h01;
        if (cnt_r == `BSL_ACK_CLOCKS - 5'h01) begin
          // hand the start to the master clock; busy keeps dout high from here
          req_tgl_nxt = ~req_tgl_r;
          dout_link_nxt = 1'b0;
          state_nxt = DS_READ;
          cnt_nxt = 5'h00;
        end
      end
      DS_READ: begin
        // the count only moves on sclk edges, so a held clock simply pauses here
        if (cnt_r == `BSL_READ_CLOCKS - 5'h01) begin
          dout_link_nxt = 1'b0;
          state_nxt = DS_IDLE;
          cnt_nxt = 5'h00;
        end else begin
          dout_link_nxt = rd_word_w[~cnt_r[3:0]];
          cnt_nxt = cnt_r + 5'h01;
        end
      end
      default: begin
        state_nxt = DS_IDLE;
        cnt_nxt = 5'h00;
      end
    endcase
    if (rst_hit_w) begin
      state_nxt = DS_IDLE;
      cnt_nxt = 5'h00;
      dout_link_nxt = 1'b0;
    end
  end

  always_ff @(posedge link.sclk or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= DS_IDLE;
      cnt_r <= 5'h00;
      setup_r <= 4'h0;
      hist_r <= 20'h00000;
      dout_link_r <= 1'b0;
      req_tgl_r <= 1'b0;
      temp_sel_r <= 1'b0;
      rd_conv_r <= 1'b0;
      cal_idx_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      setup_r <= setup_nxt;
      hist_r <= hist_w[19:0];
      dout_link_r <= dout_link_nxt;
      req_tgl_r <= req_tgl_nxt;
      temp_sel_r <= temp_sel_nxt;
      rd_conv_r <= rd_conv_nxt;
      cal_idx_r <= cal_idx_nxt;
    end
  end

  // both crossings use equal depth so busy rises in the same cycle the link bit drops
  assign start_w = tgl_sync_r[2] ^ tgl_sync_r[1];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tgl_sync_r <= 3'h0;
      dout_sync_r <= 3'h0;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], req_tgl_r};
      dout_sync_r <= {dout_sync_r[1:0], dout_link_r};
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_r <= 1'b0;
      conv_cnt_r <= 24'h000000;
      result_r <= 16'h0000;
    end else if (start_w) begin
      busy_r <= 1'b1;
      conv_cnt_r <= 24'(CONV_CYCLES - 1);
    end else if (busy_r) begin
      if (conv_cnt_r == 24'h000000) begin
        busy_r <= 1'b0;
        result_r <= temp_sel_r ? temp_value_in : pres_value_in;
      end else begin
        conv_cnt_r <= conv_cnt_r - 24'h000001;
      end
    end
  end

  // dout must fall without any sclk edge, so the pin is driven from the master clock
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dout_r <= 1'b0;
    end else begin
      dout_r <= dout_sync_r[2] | busy_r;
    end
  end

  assign link.dout = dout_r;
  assign busy_out = busy_r;
  assign result_out = result_r;
endmodule
`default_nettype wire

/* File: bsl_host.sv */
// host end of the barometer serial command link
`timescale 1ns/100ps
`default_nettype none
`include "bsl_regs.svh"
module bsl_host (
  input wire logic clk_in,
  input wire logic resetn_in,
  bsl_link_if.host link,
  input wire logic cmd_valid_in,
  input wire bsl_pkg::bsl_op_e cmd_op_in,
  output logic cmd_ready_out,
  output logic rsp_valid_out,
  output logic [15:0] rsp_data_out
);
  import bsl_pkg::*;

  // frame left-aligned in 21 bits, shifted out msb first
  function automatic logic [20:0] frame_bits(input bsl_op_e op);
    logic [3:0] code;
    code = `BSL_SETUP_PRES;
    case (op)
      BSL_OP_TEMP: code = `BSL_SETUP_TEMP;
      BSL_OP_CAL1: code = `BSL_SETUP_CAL1;
      BSL_OP_CAL2: code = `BSL_SETUP_CAL2;
      BSL_OP_CAL3: code = `BSL_SETUP_CAL3;
      BSL_OP_CAL4: code = `BSL_SETUP_CAL4;
      default: code = `BSL_SETUP_PRES;
    endcase
    if (op == BSL_OP_RESET) begin
      return `BSL_RST_PATTERN;
    end
    return {3'h7, code, 3'h0, 11'h000};
  endfunction

  function automatic logic [4:0] frame_len(input bsl_op_e op);
    logic [4:0] n;
    n = `BSL_START_BITS + `BSL_SETUP_BITS + `BSL_STOP_BITS;
    if (op == BSL_OP_RESET) begin
      n = `BSL_RST_BITS;
    end else if (op == BSL_OP_PRES || op == BSL_OP_TEMP) begin
      n = n + `BSL_ACK_CLOCKS;
    end
    return n;
  endfunction

  bsl_host_st_e state_r;
  bsl_op_e op_r;
  logic [2:0] div_r;
  logic sclk_r;
  logic din_r;
  logic [20:0] tx_r;
  logic [4:0] len_r;
  logic [4:0] cnt_r;
  logic [15:0] rx_r;
  logic [1:0] dout_sync_r;
  logic ready_r;
  logic rsp_valid_r;
  logic [15:0] rsp_data_r;

  wire logic tick_w;
  wire logic running_w;
  wire logic rise_w;
  wire logic fall_w;
  wire logic accept_w;
  wire logic [20:0] frame_w;

  assign tick_w = (div_r == `BSL_SCLK_HALF);
  assign running_w = (state_r == HS_SEND) || (state_r == HS_READ);
  assign rise_w = tick_w && !sclk_r && running_w;
  assign fall_w = tick_w && sclk_r;
  assign accept_w = cmd_valid_in && ready_r;
  assign frame_w = frame_bits(cmd_op_in);

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_r <= 3'h0;
      dout_sync_r <= 2'h0;
    end else begin
      div_r <= tick_w ? 3'h0 : div_r + 3'h1;
      dout_sync_r <= {dout_sync_r[0], link.dout};
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_r <= 1'b0;
    end else if (rise_w) begin
      sclk_r <= 1'b1;
    end else if (fall_w) begin
      sclk_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= HS_IDLE;
      op_r <= BSL_OP_RESET;
      din_r <= 1'b0;
      tx_r <= 21'h00000;
      len_r <= 5'h00;
      cnt_r <= 5'h00;
      rx_r <= 16'h0000;
      ready_r <= 1'b0;
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
    end else begin
      rsp_valid_r <= 1'b0;
      ready_r <= (state_r == HS_IDLE) && !accept_w && !sclk_r;
      case (state_r)
        HS_IDLE: begin
          if (accept_w) begin
            op_r <= cmd_op_in;
            tx_r <= frame_w;
            din_r <= frame_w[20];
            len_r <= frame_len(cmd_op_in);
            cnt_r <= 5'h00;
            state_r <= HS_SEND;
          end
        end
        HS_SEND: begin
          if (fall_w) begin
            tx_r <= {tx_r[19:0], 1'b0};
            din_r <= tx_r[19];
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == len_r - 5'h01) begin
              cnt_r <= 5'h00;
              din_r <= 1'b0;
              // a reset pattern gets no reply on dout, so nothing is sampled here
              if (op_r == BSL_OP_RESET) begin
                state_r <= HS_IDLE;
              end else if (op_r == BSL_OP_PRES || op_r == BSL_OP_TEMP) begin
                state_r <= HS_WAIT;
              end else begin
                state_r <= HS_READ;
              end
            end
          end
        end
        HS_WAIT: begin
          // sclk stays low; a stuck dout hangs here until resetn_in clears the host, as no command is taken in this state
          if (!dout_sync_r[1]) begin
            state_r <= HS_READ;
          end
        end
        HS_READ: begin
          if (fall_w) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r < `BSL_WORD_BITS) begin
              rx_r <= {rx_r[14:0], dout_sync_r[1]};
            end
            if (cnt_r == `BSL_READ_CLOCKS - 5'h01) begin
              state_r <= HS_IDLE;
              cnt_r <= 5'h00;
              rsp_valid_r <= 1'b1;
              rsp_data_r <= rx_r;
            end
          end
        end
        default: begin
          state_r <= HS_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_r;
  assign link.din = din_r;
  assign cmd_ready_out = ready_r;
  assign rsp_valid_out = rsp_valid_r;
  assign rsp_data_out = rsp_data_r;
endmodule
`default_nettype wire

/* File: bsl_link_chk.sv */
// assertions on the three-wire link between the host and sensor module ends
`timescale 1ns/100ps
`default_nettype none
`include "bsl_regs.svh"
module bsl_link_chk #(
  parameter int unsigned CONV_CYCLES = 200
) (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic sclk,
  input wire logic din,
  input wire logic dout
);
  logic sclk_q_r;
  logic [8:0] hist_r;
  logic [31:0] hi_cnt_r;
  wire rise_w = sclk && !sclk_q_r;
  wire [9:0] frame_w = {hist_r, din};
  // start, pressure or temperature code, stop
  wire conv_w = (frame_w == {3'h7, `BSL_SETUP_PRES, 3'h0}) || (frame_w == {3'h7, `BSL_SETUP_TEMP, 3'h0});

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_q_r <= 1'b0;
      hist_r <= 9'h000;
      hi_cnt_r <= 32'h0;
    end else begin
      sclk_q_r <= sclk;
      if (rise_w) begin
        hist_r <= frame_w[8:0];
      end
      hi_cnt_r <= dout ? hi_cnt_r + 32'h1 : 32'h0;
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence high_phase_s;
    sclk [*8] ##1 !sclk;
  endsequence
  sequence low_phase_s;
    !sclk [*8];
  endsequence
  sequence ack_s;
    ##[1:7] (dout && sclk);
  endsequence

  din_on_fall_a: assert property ($changed(din) |-> !sclk)
    else $error("din changed while sclk high");
  dout_on_rise_a: assert property ($rose(dout) |-> sclk)
    else $error("dout rose outside an sclk high phase");
  sclk_high_len_a: assert property ($rose(sclk) |-> high_phase_s)
    else $error("sclk high phase has the wrong length");
  sclk_low_len_a: assert property ($fell(sclk) |-> low_phase_s)
    else $error("sclk low phase too short");
  conv_ack_a: assert property (rise_w && conv_w |-> ack_s)
    else $error("no acknowledge during last stop bit");
  conv_time_a: assert property ($fell(dout) && !sclk |-> hi_cnt_r >= CONV_CYCLES + 16)
    else $error("conversion ended too early");
  conv_bound_a: assert property (dout |-> hi_cnt_r <= CONV_CYCLES + 64)
    else $error("conversion never signalled completion");
  conv_quiet_a: assert property (rise_w |-> hi_cnt_r < 100)
    else $error("sclk pulsed while conversion was running");
endmodule
`default_nettype wire

/* File: bsl_link_if.sv */
// three-wire link between host and sensor module
`timescale 1ns/100ps
`default_nettype none
interface bsl_link_if;
  logic sclk;
  logic din;
  logic dout;
  modport dev (input sclk, input din, output dout);
  modport host (output sclk, output din, input dout);
endinterface
`default_nettype wire

/* File: bsl_pkg.sv */
// types shared by both ends of the barometer serial command link
`default_nettype none
package bsl_pkg;
  typedef enum logic [2:0] {
    BSL_OP_PRES,
    BSL_OP_TEMP,
    BSL_OP_CAL1,
    BSL_OP_CAL2,
    BSL_OP_CAL3,
    BSL_OP_CAL4,
    BSL_OP_RESET
  } bsl_op_e;
  typedef enum {DS_IDLE, DS_SETUP, DS_STOP, DS_ACK, DS_READ} bsl_dev_st_e;
  typedef enum {HS_IDLE, HS_SEND, HS_WAIT, HS_READ} bsl_host_st_e;
endpackage
`default_nettype wire

/* File: bsl_regs.svh */
// constants for the barometer serial command link
`ifndef BSL_REGS_SVH
`define BSL_REGS_SVH
`define BSL_START_BITS 5'h03
`define BSL_SETUP_BITS 5'h04
`define BSL_STOP_BITS 5'h03
`define BSL_ACK_CLOCKS 5'h02
`define BSL_WORD_BITS 5'h10
`define BSL_READ_CLOCKS 5'h11
`define BSL_RST_BITS 5'h15
`define BSL_RST_PATTERN 21'h155540
`define BSL_SETUP_PRES 4'hA
`define BSL_SETUP_TEMP 4'h9
`define BSL_SETUP_CAL1 4'h5
`define BSL_SETUP_CAL2 4'h6
`define BSL_SETUP_CAL3 4'h3
`define BSL_SETUP_CAL4 4'hC
`define BSL_CAL_STORE 64'h1234_5678_9ABC_DEF0
`define BSL_CONV_TIME_US 35000
`define BSL_CLK_MHZ 250
`define BSL_CONV_CYCLES (`BSL_CONV_TIME_US * `BSL_CLK_MHZ)
`define BSL_SCLK_HALF 3'h7
`endif

/* File: tb_top.sv */
// self-checking testbench joining host and sensor module ends
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bsl_pkg::*;
  localparam int unsigned CONV = 200;
  localparam logic [63:0] CAL = 64'h0F1E_2D3C_4B5A_6978;
  logic clk_in, resetn_in, cmd_valid, cmd_ready, rsp_valid, busy;
  bsl_op_e cmd_op;
  logic [15:0] rsp_data, result, pres_val, temp_val;
  int errors, checked;

  bsl_link_if link_if();
  bsl_dev #(.CONV_CYCLES(CONV), .CAL_STORE(CAL)) u_bsl_dev (.clk_in(clk_in), .resetn_in(resetn_in),
    .link(link_if.dev), .pres_value_in(pres_val), .temp_value_in(temp_val), .busy_out(busy),
    .result_out(result));
  bsl_host u_bsl_host (.clk_in(clk_in), .resetn_in(resetn_in), .link(link_if.host),
    .cmd_valid_in(cmd_valid), .cmd_op_in(cmd_op), .cmd_ready_out(cmd_ready),
    .rsp_valid_out(rsp_valid), .rsp_data_out(rsp_data));
  bsl_link_chk #(.CONV_CYCLES(CONV)) u_bsl_link_chk (.clk_in(clk_in), .resetn_in(resetn_in),
    .sclk(link_if.sclk), .din(link_if.din), .dout(link_if.dout));

  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t ns: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // ready is a flop, so raising valid just after an edge is taken at the next one
  task automatic send(input bsl_op_e op);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 2000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({15'h0, cmd_ready}, 16'h1);
    cmd_op = op;
    cmd_valid = 1'b1;
    @(posedge clk_in);
    #1;
    cmd_valid = 1'b0;
    check({15'h0, cmd_ready}, 16'h0);
  endtask

  task automatic get_rsp(input logic [15:0] exp);
    int n;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 3000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({15'h0, rsp_valid}, 16'h1);
    check(rsp_data, exp);
    @(posedge clk_in);
    #1;
    check({15'h0, rsp_valid}, 16'h0);
  endtask

  task automatic test_cal;
    bsl_op_e ops[4];
    ops = '{BSL_OP_CAL1, BSL_OP_CAL2, BSL_OP_CAL3, BSL_OP_CAL4};
    for (int i = 0; i < 4; i++) begin
      send(ops[i]);
      get_rsp(CAL[63 - 16 * i -: 16]);
    end
    $display("test cal done");
  endtask

  task automatic test_conv(input bsl_op_e op, input logic [15:0] exp);
    int n;
    n = 0;
    send(op);
    while (busy !== 1'b1 && n < 1000) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check({15'h0, busy}, 16'h1);
    check({15'h0, link_if.dout}, 16'h1);
    get_rsp(exp);
    check(result, exp);
    check({15'h0, busy}, 16'h0);
    $display("test conversion done");
  endtask

  // a reset pattern must leave the link ready for a normal frame
  task automatic test_reset;
    send(BSL_OP_RESET);
    // a request while the pattern is still going out must be refused
    @(posedge clk_in);
    #1;
    cmd_op = BSL_OP_CAL1;
    cmd_valid = 1'b1;
    repeat (4) @(posedge clk_in);
    #1;
    cmd_valid = 1'b0;
    check({15'h0, cmd_ready}, 16'h0);
    send(BSL_OP_CAL3);
    get_rsp(CAL[31:16]);
    $display("test reset done");
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    errors++;
    test_done;
  end

  initial begin
    errors = 0;
    checked = 0;
    resetn_in = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = BSL_OP_CAL1;
    pres_val = 16'hA55A;
    temp_val = 16'h5AA5;
    repeat (2) @(posedge clk_in);
    #1;
    resetn_in = 1'b1;
    test_cal;
    test_conv(BSL_OP_PRES, 16'hA55A);
    test_conv(BSL_OP_TEMP, 16'h5AA5);
    test_reset;
    pres_val = 16'h3C96;
    test_conv(BSL_OP_PRES, 16'h3C96);
    repeat (40) @(posedge clk_in);
    #1;
    check({14'h0, link_if.sclk, link_if.dout}, 16'h0);
    test_done;
  end
endmodule
`default_nettype wire
